// ==== common/domr_pkg.sv ====
// Function
// - Sixteen storage flip-flops form two 8-bit banks, each with its own data inputs, all captured by one shared capture clock.
// - A rising edge of the capture clock loads both banks together, and at all other times both banks keep their contents.
// - Bit i of bank A and bit i of bank B feed the i-th of eight two-way multiplexers, which drives output bit i.
// - Bank select low passes bank B, bank select high passes bank A, including data just captured on a rising edge.
// - The outputs are driven only while the capture clock is high and are all released while it is low.
// - Each output can only pull low, and a released line reads high only through an external pull-up.
// - With the capture clock held high, changing bank select switches the outputs between banks without touching either bank.
package domr_pkg;

	// Width of each bank and of the output word
	localparam int DOMR_BANK_W = 8;

	// Number of banks behind each multiplexer
	localparam int DOMR_BANKS = 2;

	// Previous capture clock sample after reset; low so a high pin loads
	localparam logic DOMR_CAP_PREV_RST = 1'b0;

	// Bank loaded flag after reset
	localparam logic DOMR_LOADED_RST = 1'b0;

	// Level an open-collector pin drives when enabled
	localparam logic DOMR_PIN_LOW = 1'b0;

	// Level a bank select must have to pass bank A
	localparam logic DOMR_SEL_A = 1'b1;

endpackage

// ==== rtl/domr_bank.sv ====
`timescale 1ns/1ps
`default_nettype none

// One storage bank: plain D flip-flops with a load strobe and no reset,
// so contents stay unknown until the first load.
module domr_bank
	import domr_pkg::*;
#(
	parameter int W = DOMR_BANK_W
) (
	// Clock
	input  wire logic         mclk,
	// Load strobe and data
	input  wire logic         load,
	input  wire logic [W-1:0] d,
	// Stored contents
	output logic      [W-1:0] q
);

	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	// Load on strobe, otherwise hold
	always_comb begin
		q_nxt = q_r;
		if (load) begin
			q_nxt = d;
		end
	end

	// No reset on purpose: data flops cost less and power-up is unknown
	always_ff @(posedge mclk) begin
		q_r <= q_nxt;
	end

	assign q = q_r;

endmodule

`default_nettype wire

// ==== rtl/domr_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Dual octal register with multiplexed open-collector outputs.
// The capture clock pin is sampled on mclk like any other input; its
// rising edge is found by comparing with the previous sample.
module domr_top
	import domr_pkg::*;
#(
	parameter int W = DOMR_BANK_W
) (
	// System clock and reset
	input  wire logic         mclk,
	input  wire logic         nrst,
	// Capture clock pin
	input  wire logic         capture_clock,
	// Data inputs of both banks
	input  wire logic [W-1:0] bank_a_inputs,
	input  wire logic [W-1:0] bank_b_inputs,
	// Bank select, high passes bank A
	input  wire logic         bank_select,
	// Open-collector output pins
	input  wire logic [W-1:0] mux_outputs_in,
	output logic      [W-1:0] mux_outputs_out,
	output logic      [W-1:0] mux_outputs_oe,
	// Registered level seen on the output lines
	output logic      [W-1:0] bus_level
);

	// Per-bit two-way multiplexer, select high takes bank A.
	// One function serves the load edge and the stored path, so both agree.
	function automatic logic [W-1:0] domr_pick(
		input logic         sel,
		input logic [W-1:0] a,
		input logic [W-1:0] b
	);
		logic [W-1:0] res;
		res = '0;
		for (int i = 0; i < W; i++) begin
			res[i] = (sel == DOMR_SEL_A) ? a[i] : b[i];
		end
		return res;
	endfunction

	logic         cap_prev_r;
	logic         cap_prev_nxt;
	logic         cap_rise;
	logic [W-1:0] bank_a_q;
	logic [W-1:0] bank_b_q;
	logic [W-1:0] pick_nxt;
	logic [W-1:0] oe_r;
	logic [W-1:0] oe_nxt;
	logic [W-1:0] out_r;
	logic [W-1:0] out_nxt;
	logic [W-1:0] level_r;
	logic [W-1:0] level_nxt;
	logic         loaded_r;
	logic         loaded_nxt;

	// Edge detect on the sampled capture clock
	always_comb begin
		cap_prev_nxt = capture_clock;
		cap_rise     = capture_clock & ~cap_prev_r;
	end

	// Reset value low: a pin already high at release counts as an edge,
	// so the outputs never show the unknown power-up bank contents
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cap_prev_r <= DOMR_CAP_PREV_RST;
		end else begin
			cap_prev_r <= cap_prev_nxt;
		end
	end

	// Two banks sharing one load strobe
	domr_bank #(
		.W (W)
	) u_bank_a (
		.mclk (mclk),
		.load (cap_rise),
		.d    (bank_a_inputs),
		.q    (bank_a_q)
	);

	domr_bank #(
		.W (W)
	) u_bank_b (
		.mclk (mclk),
		.load (cap_rise),
		.d    (bank_b_inputs),
		.q    (bank_b_q)
	);

	// Multiplexer and output gating. On the load edge the fresh inputs
	// are passed through, since the banks only show them one edge later.
	always_comb begin
		if (cap_rise) begin
			pick_nxt = domr_pick(bank_select, bank_a_inputs,
				bank_b_inputs);
		end else begin
			pick_nxt = domr_pick(bank_select, bank_a_q, bank_b_q);
		end
		// Enable only the bits that pull low, released while clock low
		if (capture_clock) begin
			oe_nxt = ~pick_nxt;
		end else begin
			oe_nxt = '0;
		end
		// Open collector: the driven level is always low
		out_nxt   = {W{DOMR_PIN_LOW}};
		// Lines are read back as the pull-ups leave them, one cycle late
		level_nxt = mux_outputs_in;
	end

	// Output pin registers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			oe_r    <= '0;
			out_r   <= '0;
			level_r <= '0;
		end else begin
			oe_r    <= oe_nxt;
			out_r   <= out_nxt;
			level_r <= level_nxt;
		end
	end

	assign mux_outputs_oe  = oe_r;
	assign mux_outputs_out = out_r;
	assign bus_level       = level_r;

	// Helper for checks only: set once both banks have been loaded
	always_comb begin
		loaded_nxt = loaded_r | cap_rise;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			loaded_r <= DOMR_LOADED_RST;
		end else begin
			loaded_r <= loaded_nxt;
		end
	end

	// Both banks take their inputs on a capture edge
	load_both_banks_a: assert property (
		@(posedge mclk) disable iff (!nrst)
		cap_rise |=> (bank_a_q == $past(bank_a_inputs)) &&
			(bank_b_q == $past(bank_b_inputs)))
	else $error("banks did not load on capture edge");

	// Banks hold between capture edges
	hold_banks_a: assert property (
		@(posedge mclk) disable iff (!nrst)
		(loaded_r && !cap_rise) |=> $stable(bank_a_q) && $stable(bank_b_q))
	else $error("bank changed without capture edge");

	// Low capture clock releases every line
	release_low_a: assert property (
		@(posedge mclk) disable iff (!nrst)
		!capture_clock |=> (mux_outputs_oe == '0))
	else $error("output driven while capture clock low");

	// Select low passes stored bank B
	pick_bank_b_a: assert property (
		@(posedge mclk) disable iff (!nrst)
		(capture_clock && !cap_rise && !bank_select)
			|=> (mux_outputs_oe == ~$past(bank_b_q)))
	else $error("bank B not passed with select low");

	// Select high passes stored bank A, bit for bit
	pick_bank_a_a: assert property (
		@(posedge mclk) disable iff (!nrst)
		(capture_clock && !cap_rise && bank_select)
			|=> (mux_outputs_oe == ~$past(bank_a_q)))
	else $error("bank A not passed with select high");

	// Data captured on the edge shows on the very next cycle
	fresh_data_a: assert property (
		@(posedge mclk) disable iff (!nrst)
		cap_rise |=> (mux_outputs_oe == ($past(bank_select) ?
			~$past(bank_a_inputs) : ~$past(bank_b_inputs))))
	else $error("captured data not shown after edge");

	// Open collector never drives high
	pull_low_only_a: assert property (
		@(posedge mclk) disable iff (!nrst)
		(mux_outputs_oe != '0) |-> (mux_outputs_out == '0))
	else $error("open-collector output driven high");

	// Select toggle while high swaps halves and leaves banks alone
	select_swap_a: assert property (
		@(posedge mclk) disable iff (!nrst)
		(capture_clock && cap_prev_r && (bank_select != $past(bank_select)))
			|=> $stable(bank_a_q) && $stable(bank_b_q) &&
			(mux_outputs_oe == ($past(bank_select) ?
			~$past(bank_a_q) : ~$past(bank_b_q))))
	else $error("select toggle disturbed banks or outputs");

	// Nothing is driven before the first load
	unloaded_quiet_a: assert property (
		@(posedge mclk) disable iff (!nrst)
		!loaded_r |-> (mux_outputs_oe == '0))
	else $error("output driven before first capture");

	// Outputs only ever pull while the capture clock was seen high
	drive_when_high_a: assert property (
		@(posedge mclk) disable iff (!nrst)
		(mux_outputs_oe != '0) |-> $past(capture_clock))
	else $error("output driven after capture clock low");

	// Held select and no load keep the outputs steady
	steady_out_a: assert property (
		@(posedge mclk) disable iff (!nrst)
		(capture_clock && cap_prev_r && $stable(bank_select))
			|=> $stable(mux_outputs_oe))
	else $error("outputs moved with select held");

	// Line level is reported one cycle after it is seen
	level_follow_a: assert property (
		@(posedge mclk) disable iff (!nrst)
		1'h1 |=> (bus_level == $past(mux_outputs_in)))
	else $error("line level not registered");

endmodule

`default_nettype wire

// ==== test/domr_bus_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Output lines with external pull-ups, as the receiving bus sees them.
// A driver that asserts its enable with a high level is not helped here:
// the line shows that level, so a wrong drive value gets seen.
module domr_bus_model
	import domr_pkg::*;
#(
	parameter int W = DOMR_BANK_W
) (
	// Pin side of the open-collector outputs
	input  wire logic [W-1:0] pin_out,
	input  wire logic [W-1:0] pin_oe,
	// Resolved level on each line
	output logic      [W-1:0] line
);
	// Released lines rise through the pull-up
	always_comb begin
		for (int i = 0; i < W; i++) begin
			line[i] = pin_oe[i] ? pin_out[i] : 1'b1;
		end
	end
endmodule

`default_nettype wire

// ==== test/domr_top_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

module domr_top_tb_top
	import domr_pkg::*;
;
	logic                   mclk;
	logic                   nrst;
	logic                   capture_clock;
	logic                   bank_select;
	logic [DOMR_BANK_W-1:0] bank_a_inputs;
	logic [DOMR_BANK_W-1:0] bank_b_inputs;
	logic [DOMR_BANK_W-1:0] line;
	logic [DOMR_BANK_W-1:0] q_out;
	logic [DOMR_BANK_W-1:0] q_oe;
	logic [DOMR_BANK_W-1:0] lvl;
	int                     miscompares;
	int                     samples_checked;
	int                     cycles;

	domr_top #(.W(DOMR_BANK_W)) domr_top_inst (
		.mclk(mclk), .nrst(nrst), .capture_clock(capture_clock),
		.bank_a_inputs(bank_a_inputs), .bank_b_inputs(bank_b_inputs),
		.bank_select(bank_select), .mux_outputs_in(line),
		.mux_outputs_out(q_out), .mux_outputs_oe(q_oe), .bus_level(lvl)
	);

	domr_bus_model #(.W(DOMR_BANK_W)) domr_bus_model_inst (
		.pin_out(q_out), .pin_oe(q_oe), .line(line)
	);

	// Clock at 40 MHz
	always #12.5 mclk = ~mclk;

	// Verdict needs no mismatch and at least one comparison
	task automatic summarize();
		if (miscompares == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// Generous ceiling; the whole run needs under a hundred cycles
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 2000) begin
			miscompares++;
			summarize();
		end
	end

	// Four-state compare, so an unknown never passes
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Called at a falling edge; the next rising edge samples these
	task automatic drive(input logic c, input logic [7:0] a,
		input logic [7:0] b, input logic s);
		capture_clock = c;
		bank_a_inputs = a;
		bank_b_inputs = b;
		bank_select   = s;
	endtask

	// One word captured, read back as two halves, data changed meanwhile
	task automatic t_capture_read();
		logic [7:0] pa [4];
		pa = '{8'h12, 8'h80, 8'hff, 8'h01};
		for (int i = 0; i < 4; i++) begin
			drive(1'b0, 8'h00, 8'h00, 1'b1);
			@(negedge mclk);
			drive(1'b1, pa[i], ~pa[i], 1'b1);
			@(negedge mclk);
			check(line, pa[i]);
			drive(1'b1, 8'h5a, 8'ha5, 1'b0);
			@(negedge mclk);
			check(line, ~pa[i]);
			check(lvl, pa[i]);
			drive(1'b1, 8'h66, 8'h99, 1'b1);
			@(negedge mclk);
			check(line, pa[i]);
		end
	endtask

	// Clock low releases every line whatever the select and data
	task automatic t_release();
		drive(1'b0, 8'h00, 8'h00, 1'b1);
		@(negedge mclk);
		check(q_oe, 8'h00);
		check(line, 8'hff);
		drive(1'b0, 8'hff, 8'h00, 1'b0);
		@(negedge mclk);
		check(line, 8'hff);
		drive(1'b1, 8'h3c, 8'hc3, 1'b0);
		@(negedge mclk);
		check(line, 8'hc3);
		check(q_out & q_oe, 8'h00);
	endtask

	// Reset in mid-run with the clock pin high: first edge after is a rise
	task automatic t_reset_mid();
		nrst = 1'b0;
		drive(1'b1, 8'he7, 8'h18, 1'b1);
		@(negedge mclk);
		check(q_oe, 8'h00);
		nrst = 1'b1;
		@(negedge mclk);
		check(line, 8'he7);
		drive(1'b1, 8'h00, 8'h00, 1'b0);
		@(negedge mclk);
		check(line, 8'h18);
		// Select held with the clock high: new data must not leak out
		drive(1'b1, 8'hff, 8'hff, 1'b0);
		@(negedge mclk);
		check(line, 8'h18);
	endtask

	// Reset for two cycles, then every scenario in turn
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		miscompares = 0;
		samples_checked = 0;
		cycles = 0;
		drive(1'b0, 8'h00, 8'h00, 1'b0);
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		nrst = 1'b1;
		t_capture_read();
		t_release();
		t_reset_mid();
		summarize();
	end
endmodule

`default_nettype wire
